/* sfp_cfg.svh */
// sfp_cfg.svh: constants of the serial flash port (geometry, fields, opcodes)
// assumes: included by bare name from the package and the design modules
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// ----------------------------------------------------------------
// serial framing
// ----------------------------------------------------------------
`define SFP_BYTE_W      8
`define SFP_BIT_W       3
`define SFP_LAST_BIT    3'h7
`define SFP_IDX_W       9
`define SFP_IDX_MAX     9'h1ff
`define SFP_OP_END      9'h001
`define SFP_ADDR_END    9'h004

// ----------------------------------------------------------------
// memory geometry: 64 sectors x 1024 pages x 256 bytes
// ----------------------------------------------------------------
`define SFP_SECTORS     7'h40
`define SFP_SECTOR_W    6
`define SFP_PAGE_W      10
`define SFP_OFFSET_W    8
`define SFP_ADDR_W      24
`define SFP_SEC_LSB     18
`define SFP_PAGE_LSB    8
`define SFP_PAGE_BYTES  9'h100

// ----------------------------------------------------------------
// status byte: area guard field
// ----------------------------------------------------------------
`define SFP_GUARD_W     3
`define SFP_GUARD_LSB   2

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SFP_OP_PROG     8'h11
`define SFP_OP_SECT     8'h22
`define SFP_OP_BULK     8'h33
`define SFP_OP_STAT     8'h44
`define SFP_OP_IDENT    8'h55

`endif

/* sfp_guard.sv */
// sfp_guard.sv: protected-area check for program and erase
// assumes: guard is the 3-bit area guard field, sector from the address
`timescale 1ns/100ps
`default_nettype none
`include "sfp_cfg.svh"

module sfp_guard (
   input  wire logic [`SFP_GUARD_W-1:0]  guard,
   input  wire logic [`SFP_SECTOR_W-1:0] sector,
   input  wire logic                     whole,
   output logic                          barred
);

   logic [`SFP_SECTOR_W:0] first;   // lowest protected sector

   // ----------------------------------------------------------------
   // guard n protects the upper 2^(n-1) sectors; guard 0 wraps the
   // shift to zero so first lands past the top and nothing is barred
   // ----------------------------------------------------------------
   always_comb
   begin
      first  = `SFP_SECTORS - (7'h01 << (guard - 3'h1));
      barred = whole ? (guard != '0) : ({1'b0, sector} >= first);
   end

endmodule
`default_nettype wire

/* sfp_master.sv */
// sfp_master.sv: bus master model that drives the flash port pins
// assumes: CLK is the port clock; link half period is 10 CLK
`timescale 1ns/100ps
`default_nettype none
module sfp_master (
   input  wire logic CLK,
   input  wire logic Q_LINE,
   output logic      SCK,
   output logic      SDI,
   output logic      CS_N,
   output logic      HOLD_N
);
   logic [7:0] r;      // byte being read
   logic [7:0] rx[$];  // bytes read in the frame
   initial {SCK, SDI, CS_N, HOLD_N} = 4'h3;
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // drive on the fall, sample on the rise
   task automatic bit_x(input logic d);
      SCK <= 1'b0;
      SDI <= d;
      tick(10);
      SCK <= 1'b1;
      r = {r[6:0], Q_LINE};
      tick(10);
   endtask
   // one frame: pause before byte hb, xb stray bits at the end
   task automatic frame(input logic pol, input logic [7:0] b[$], input int xb, input int hb);
      rx = {};
      // settle the idle level first so select never meets a clock edge
      SCK <= pol;
      tick(10);
      CS_N <= 1'b0;
      tick(10);
      foreach (b[i])
      begin
         if (i == hb)
         begin
            SCK <= 1'b0;
            tick(10);
            HOLD_N <= 1'b0;
            repeat (4) bit_x(~SDI); // clock and data must be ignored
            SCK <= 1'b0;
            tick(10);
            HOLD_N <= 1'b1;
            tick(10);
         end
         for (int k = 7; k >= 0; k--) bit_x(b[i][k]);
         rx.push_back(r);
      end
      repeat (xb) bit_x(1'b1);
      SCK <= pol;
      tick(10);
      CS_N <= 1'b1;
      SDI <= ~SDI; // released line does not keep its value
      tick(10);
   endtask
   // deselect inside a pause, reselect with pause released: bits go unheard
   task automatic cut();
      CS_N <= 1'b0;
      tick(10);
      HOLD_N <= 1'b0;
      tick(10);
      CS_N <= 1'b1;
      tick(10);
      CS_N <= 1'b0;
      HOLD_N <= 1'b1;
      repeat (8) bit_x(1'b1);
      SCK <= 1'b0;
      tick(10);
      CS_N <= 1'b1;
      tick(10);
   endtask
endmodule
`default_nettype wire

/* sfp_pkg.sv */
// sfp_pkg.sv: types shared by the serial flash port modules
// assumes: sfp_cfg.svh on the include path
`include "sfp_cfg.svh"

package sfp_pkg;

   // frame phase, one-hot
   typedef enum logic [3:0] {
      PH_IDLE   = 4'h1,
      PH_OPCODE = 4'h2,
      PH_ADDR   = 4'h4,
      PH_DATA   = 4'h8
   } sfp_phase_t;

   // kind of committed write-class command, one-hot
   typedef enum logic [3:0] {
      KIND_PROG = 4'h1,
      KIND_SECT = 4'h2,
      KIND_BULK = 4'h4,
      KIND_STAT = 4'h8
   } sfp_kind_t;

   // pins as sampled, grouped for the synchroniser
   typedef struct packed {
      logic sck;
      logic sdi;
      logic cs_n;
      logic hold_n;
      logic wp_n;
   } sfp_pins_t;

   // committed command handed to the array core
   typedef struct packed {
      sfp_kind_t                   kind;
      logic [`SFP_SECTOR_W-1:0]    sector;
      logic [`SFP_PAGE_W-1:0]      page;
      logic [`SFP_OFFSET_W-1:0]    offset;
      logic [`SFP_IDX_W-1:0]       count;
   } sfp_cmd_t;

endpackage

/* sfp_port.sv */
// sfp_port.sv: serial bus front end of a 128-Mbit serial flash
// assumes: pins arrive asynchronously; the array core sits on the user
// side, supplies read bytes on TX_DATA and reports BUSY
//
// Operation
// - output bits change on clock falling edge
// - input bit sampled on every clock rise
// - deselected: output released to high impedance
// - standby only when deselected and core idle
// - ignore input until first chip select fall
// - hold: output released, clock and data ignored
// - write protect freezes area guard bits
// - address splits 64 sectors, 1024 pages, 256 bytes
// - page program takes 1 to 256 bytes
// - erase whole sector or whole array only
// - two-byte signature readable over link
// - clock modes 0 and 3 both served
// - hold changes only while clock is low
// - select rise in hold resets, locks out
// - write commands need bit count multiple eight
`timescale 1ns/100ps
`default_nettype none
`include "sfp_cfg.svh"

module sfp_port #(
   parameter logic [15:0] ID_SIG = 16'h5a3c   // arbitrary value
) (
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   input  wire logic              SCK,
   input  wire logic              SDI,
   input  wire logic              CS_N,
   input  wire logic              HOLD_N,
   input  wire logic              WP_N,
   input  wire logic              BUSY,
   input  wire logic [7:0]        TX_DATA,
   output logic                   SDO_O,
   output logic                   SDO_OE,
   output logic [7:0]             RX_DATA,
   output logic                   RX_VALID,
   output logic [8:0]             RX_INDEX,
   output logic                   CMD_GO,
   output logic                   CMD_REJ,
   output var sfp_pkg::sfp_cmd_t  CMD,
   output logic [2:0]             AREA_GUARD,
   output logic                   SELECTED,
   output logic                   STANDBY,
   output logic                   HOLD_ACTIVE
);
   import sfp_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   sfp_pins_t                pins_raw;     // pins as they arrive
   sfp_pins_t                pins_s;       // pins after two flops
   logic                     sck_q;        // previous synced clock
   logic                     csn_q;        // previous synced select
   logic                     armed_r;      // first select fall seen
   logic                     lock_r;       // select rose inside hold
   logic                     hold_r;       // hold condition in force
   logic [`SFP_BIT_W-1:0]    bit_cnt_r;    // clock rises mod eight
   logic [7:0]               rx_sh_r;      // incoming bits
   logic [7:0]               tx_sh_r;      // outgoing bits
   logic [`SFP_IDX_W-1:0]    byte_idx_r;   // whole bytes this frame
   logic [`SFP_IDX_W-1:0]    data_cnt_r;   // bytes after address
   logic [7:0]               op_r;         // instruction byte
   logic [`SFP_ADDR_W-1:0]   addr_r;       // address bytes
   logic [7:0]               stat_r;       // first status-write byte
   sfp_phase_t               phase_r;      // frame phase
   logic                     active;       // selected, armed and not locked out
   logic                     sck_rise;
   logic                     sck_fall;
   logic                     cs_rise;
   logic                     cs_fall;
   logic                     byte_done;
   logic [7:0]               new_byte;
   logic [7:0]               tx_src;       // byte loaded at boundary
   logic                     whole;        // bulk erase in hand
   logic                     barred;       // target lies in guarded area
   logic                     wr_class;     // program, erase, status write
   logic                     shape_ok;     // byte counts fit the opcode
   sfp_kind_t                kind_nxt;

   // ----------------------------------------------------------------
   // pin synchronisers; idle levels preset so reset shows no edge
   // ----------------------------------------------------------------
   always_comb
   begin
      pins_raw = '{sck: SCK, sdi: SDI, cs_n: CS_N, hold_n: HOLD_N, wp_n: WP_N};
   end

   sfp_sync #(
      .W    (5),
      .INIT (5'h07)
   ) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .d     (pins_raw),
      .q     (pins_s)
   );

   // ----------------------------------------------------------------
   // edge finding on the synced link clock and select
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         sck_q <= 1'b0;
         csn_q <= 1'b1;
      end
      else if (CE)
      begin
         // tracked through hold too, so release makes no false edge
         sck_q <= pins_s.sck;
         csn_q <= pins_s.cs_n;
      end
   end

   // both clock modes look alike here: only edges count, never idle level
   always_comb
   begin
      active    = !pins_s.cs_n && armed_r && !lock_r;
      sck_rise  = pins_s.sck && !sck_q && active && !hold_r;
      sck_fall  = !pins_s.sck && sck_q && active && !hold_r;
      cs_rise   = pins_s.cs_n && !csn_q;
      cs_fall   = !pins_s.cs_n && csn_q;
      byte_done = sck_rise && (bit_cnt_r == `SFP_LAST_BIT);
      new_byte  = {rx_sh_r[6:0], pins_s.sdi};
   end

   // ----------------------------------------------------------------
   // power-up arming: nothing is heard before the first select fall
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         armed_r <= 1'b0;
      else if (CE && cs_fall)
         armed_r <= 1'b1;
   end

   // ----------------------------------------------------------------
   // hold: follows the pin only while the link clock is low
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         hold_r <= 1'b0;
         lock_r <= 1'b0;
      end
      else if (CE)
      begin
         if (cs_rise)
         begin
            hold_r <= 1'b0;
            // a second rise while still locked must not unlock
            lock_r <= hold_r || lock_r;
         end
         else if (active && !pins_s.sck)
            hold_r <= !pins_s.hold_n;
         // the lock needs hold released while deselected
         if (!cs_rise && pins_s.cs_n && pins_s.hold_n)
            lock_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // shift in on rises; deselect drops any partial byte
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         bit_cnt_r <= '0;
         rx_sh_r   <= '0;
      end
      else if (CE)
      begin
         if (pins_s.cs_n)
         begin
            bit_cnt_r <= '0;
            rx_sh_r   <= '0;
         end
         else if (sck_rise)
         begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r   <= new_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame phase: opcode, then address, then data
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         phase_r    <= PH_IDLE;
         op_r       <= '0;
         addr_r     <= '0;
         stat_r     <= '0;
         byte_idx_r <= '0;
         data_cnt_r <= '0;
      end
      else if (CE)
      begin
         if (pins_s.cs_n)
         begin
            phase_r    <= PH_IDLE;
            byte_idx_r <= '0;
            data_cnt_r <= '0;
         end
         else if (active)
         begin
            if (byte_done && byte_idx_r != `SFP_IDX_MAX)
               byte_idx_r <= byte_idx_r + 9'h001;
            case (phase_r)
               PH_IDLE:
                  phase_r <= PH_OPCODE;
               PH_OPCODE:
                  if (byte_done)
                  begin
                     op_r    <= new_byte;
                     phase_r <= (new_byte == `SFP_OP_PROG || new_byte == `SFP_OP_SECT)
                                ? PH_ADDR : PH_DATA;
                  end
               PH_ADDR:
                  if (byte_done)
                  begin
                     addr_r <= {addr_r[15:0], new_byte};
                     if (byte_idx_r + 9'h001 == `SFP_ADDR_END)
                        phase_r <= PH_DATA;
                  end
               PH_DATA:
                  if (byte_done)
                  begin
                     if (data_cnt_r == '0)
                        stat_r <= new_byte;
                     // count stops at a page; extra bytes do not widen it
                     if (data_cnt_r != `SFP_PAGE_BYTES)
                        data_cnt_r <= data_cnt_r + 9'h001;
                  end
               default:
                  phase_r <= PH_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // byte source for output: signature after its opcode, else core
   // ----------------------------------------------------------------
   always_comb
   begin
      tx_src = TX_DATA;
      if (phase_r == PH_DATA && op_r == `SFP_OP_IDENT)
         tx_src = (byte_idx_r == `SFP_OP_END) ? ID_SIG[15:8] : ID_SIG[7:0];
   end

   // ----------------------------------------------------------------
   // shift out on falls; a new byte loads at each byte boundary
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         tx_sh_r <= '0;
         SDO_O   <= 1'b0;
         SDO_OE  <= 1'b0;
      end
      else if (CE)
      begin
         SDO_OE <= active && !hold_r;
         if (sck_fall)
         begin
            if (bit_cnt_r == '0)
            begin
               SDO_O   <= tx_src[7];
               tx_sh_r <= {tx_src[6:0], 1'b0};
            end
            else
            begin
               SDO_O   <= tx_sh_r[7];
               tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // command checks at select rise
   // ----------------------------------------------------------------
   always_comb
   begin
      whole    = (op_r == `SFP_OP_BULK);
      wr_class = (op_r == `SFP_OP_PROG) || (op_r == `SFP_OP_SECT) || whole
                 || (op_r == `SFP_OP_STAT);
      kind_nxt = KIND_STAT;
      shape_ok = (data_cnt_r != '0);
      case (op_r)
         `SFP_OP_PROG:
            kind_nxt = KIND_PROG;
         `SFP_OP_SECT:
         begin
            kind_nxt = KIND_SECT;
            shape_ok = (byte_idx_r == `SFP_ADDR_END);
         end
         `SFP_OP_BULK:
         begin
            kind_nxt = KIND_BULK;
            shape_ok = (byte_idx_r == `SFP_OP_END);
         end
         default:
            kind_nxt = KIND_STAT;
      endcase
   end

   sfp_guard u_guard (
      .guard  (AREA_GUARD),
      .sector (addr_r[`SFP_ADDR_W-1:`SFP_SEC_LSB]),
      .whole  (whole),
      .barred (barred)
   );

   // ----------------------------------------------------------------
   // commit: a frame that ends inside hold, or off a byte edge, dies
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         CMD_GO     <= 1'b0;
         CMD_REJ    <= 1'b0;
         CMD        <= '{kind: KIND_STAT, default: '0};
         AREA_GUARD <= '0;
      end
      else if (CE)
      begin
         CMD_GO  <= 1'b0;
         CMD_REJ <= 1'b0;
         if (cs_rise && armed_r && !lock_r && !hold_r && wr_class)
         begin
            if (bit_cnt_r == '0 && shape_ok
                && (kind_nxt == KIND_STAT || !barred))
            begin
               CMD_GO     <= 1'b1;
               CMD.kind   <= kind_nxt;
               CMD.sector <= addr_r[`SFP_ADDR_W-1:`SFP_SEC_LSB];
               CMD.page   <= addr_r[`SFP_SEC_LSB-1:`SFP_PAGE_LSB];
               CMD.offset <= addr_r[`SFP_PAGE_LSB-1:0];
               CMD.count  <= data_cnt_r;
               // guard bits cannot move while write protect is low
               if (kind_nxt == KIND_STAT && pins_s.wp_n)
                  AREA_GUARD <= stat_r[`SFP_GUARD_LSB+`SFP_GUARD_W-1:`SFP_GUARD_LSB];
            end
            else
               CMD_REJ <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // user-side status flags and received bytes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         RX_DATA     <= '0;
         RX_VALID    <= 1'b0;
         RX_INDEX    <= '0;
         SELECTED    <= 1'b0;
         STANDBY     <= 1'b0;
         HOLD_ACTIVE <= 1'b0;
      end
      else if (CE)
      begin
         RX_VALID    <= byte_done;
         if (byte_done)
         begin
            RX_DATA  <= new_byte;
            RX_INDEX <= byte_idx_r;
         end
         SELECTED    <= active;
         STANDBY     <= pins_s.cs_n && !BUSY;
         HOLD_ACTIVE <= hold_r;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N || !CE);

   property p_out_on_fall;
      $changed(SDO_O) |-> $past(!pins_s.sck && sck_q);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a fall");

   property p_rx_on_rise;
      RX_VALID |-> $past(pins_s.sck && !sck_q && bit_cnt_r == `SFP_LAST_BIT);
   endproperty
   a_rx_on_rise: assert property (p_rx_on_rise) else $error("byte not closed by a rise");

   property p_desel_off;
      pins_s.cs_n ##1 pins_s.cs_n |-> !SDO_OE;
   endproperty
   a_desel_off: assert property (p_desel_off) else $error("output driven while deselected");

   property p_standby;
      STANDBY |-> $past(pins_s.cs_n && !BUSY);
   endproperty
   a_standby: assert property (p_standby) else $error("standby while busy or selected");

   property p_unarmed;
      !armed_r |=> !RX_VALID && !CMD_GO;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("input heard before arming");

   property p_hold_quiet;
      hold_r |=> !SDO_OE && !RX_VALID;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("link active during hold");

   property p_guard_frozen;
      $changed(AREA_GUARD) |-> $past(pins_s.wp_n) && CMD_GO;
   endproperty
   a_guard_frozen: assert property (p_guard_frozen) else $error("guard moved under protect");

   property p_prog_count;
      CMD_GO && CMD.kind == KIND_PROG |-> CMD.count != '0 && CMD.count <= `SFP_PAGE_BYTES;
   endproperty
   a_prog_count: assert property (p_prog_count) else $error("program count out of range");

   property p_hold_low_clk;
      $changed(hold_r) && !cs_rise && !$past(cs_rise) |-> $past(!pins_s.sck);
   endproperty
   a_hold_low_clk: assert property (p_hold_low_clk) else $error("hold moved with clock high");

   property p_lockout;
      lock_r |=> !SELECTED ##1 !SELECTED;
   endproperty
   a_lockout: assert property (p_lockout) else $error("selected while locked");

   property p_bit_multiple;
      CMD_GO |-> $past(bit_cnt_r == '0 && cs_rise);
   endproperty
   a_bit_multiple: assert property (p_bit_multiple) else $error("commit off a byte edge");

   property p_frame_clear;
      cs_rise |=> bit_cnt_r == '0 && phase_r == PH_IDLE && byte_idx_r == '0;
   endproperty
   a_frame_clear: assert property (p_frame_clear) else $error("frame state kept");

   c_prog:  cover property (CMD_GO && CMD.kind == KIND_PROG);
   c_hold:  cover property ($rose(hold_r) ##[1:200] $fell(hold_r));
   c_ident: cover property (RX_VALID && op_r == `SFP_OP_IDENT);
   c_rej:   cover property (CMD_REJ);

endmodule
`default_nettype wire

/* sfp_port_test.sv */
// sfp_port_test.sv: self-checking bench of the serial flash port
// assumes: sfp_master drives the link; core side is a plain stimulus
`timescale 1ns/100ps
`default_nettype none
module sfp_port_test;
   import sfp_pkg::*;
   localparam logic [15:0] ID = 16'h3c96; // arbitrary value
   logic CLK, RST_N, CE, SCK, SDI, CS_N, HOLD_N, WP_N, BUSY, SDO_O, SDO_OE;
   logic RX_VALID, CMD_GO, CMD_REJ, SELECTED, STANDBY, HOLD_ACTIVE;
   logic [7:0] TX_DATA, RX_DATA, last_rx;
   logic [8:0] RX_INDEX, last_idx;
   logic [2:0] AREA_GUARD;
   sfp_cmd_t   CMD;
   wire logic  q_line = SDO_OE ? SDO_O : 1'bz;
   int n_mismatch, total_checks, n_go, n_rej, n_hold, n_hoe, n_rx, n_sel;
   sfp_port #(.ID_SIG(ID)) i_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .SCK(SCK), .SDI(SDI),
      .CS_N(CS_N), .HOLD_N(HOLD_N), .WP_N(WP_N), .BUSY(BUSY), .TX_DATA(TX_DATA),
      .SDO_O(SDO_O), .SDO_OE(SDO_OE), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
      .RX_INDEX(RX_INDEX), .CMD_GO(CMD_GO), .CMD_REJ(CMD_REJ), .CMD(CMD),
      .AREA_GUARD(AREA_GUARD), .SELECTED(SELECTED), .STANDBY(STANDBY),
      .HOLD_ACTIVE(HOLD_ACTIVE));
   sfp_master i_mst (.CLK(CLK), .Q_LINE(q_line), .SCK(SCK), .SDI(SDI), .CS_N(CS_N),
      .HOLD_N(HOLD_N));
   // pulse and pause monitors
   // sampled on the falling edge, away from the edge that launches outputs
   always @(negedge CLK)
   begin
      if (CMD_GO === 1'b1) n_go++;
      if (CMD_REJ === 1'b1) n_rej++;
      if (RX_VALID === 1'b1) last_rx = RX_DATA;
      if (RX_VALID === 1'b1) last_idx = RX_INDEX;
      if (RX_VALID === 1'b1) n_rx++;
      if (SELECTED === 1'b1) n_sel++;
      if (HOLD_ACTIVE === 1'b1) n_hold++;
      if (HOLD_ACTIVE === 1'b1 && SDO_OE !== 1'b0) n_hoe++;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pulses of one frame, then clear
   task automatic res(input int g, input int j);
      chk(n_go, g);
      chk(n_rej, j);
      n_go = 0;
      n_rej = 0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   // whole run is about 22 us
   initial
   begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      {RST_N, CE, WP_N, BUSY, TX_DATA} = {4'h6, 8'ha5};
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (6) @(posedge CLK);
      chk(STANDBY, 1'b1);
      BUSY <= 1'b1;
      repeat (3) @(posedge CLK);
      chk(STANDBY, 1'b0);
      BUSY <= 1'b0;
      i_mst.frame(0, '{8'h22, 8'h14, 8'h00, 8'h00}, 0, 2);
      res(1, 0);
      chk({CMD.kind, CMD.sector}, {KIND_SECT, 6'h05});
      chk(n_sel > 0, 1);
      chk(n_hold > 0 && n_hoe == 0, 1);
      i_mst.frame(0, '{8'h11, 8'h00, 8'h01, 8'h02, 8'haa, 8'h5b}, 0, 9);
      res(1, 0);
      chk(CMD, {KIND_PROG, 6'h00, 10'h001, 8'h02, 9'h002});
      chk(last_rx, 8'h5b);
      chk(last_idx, 9'h005);
      chk(i_mst.rx[5], 8'ha5);
      i_mst.frame(0, '{8'h44, 8'h04}, 0, 9);
      res(1, 0);
      chk(AREA_GUARD, 3'h1);
      i_mst.frame(0, '{8'h22, 8'hfc, 8'h00, 8'h00}, 0, 9);
      res(0, 1);
      i_mst.frame(0, '{8'h33}, 0, 9);
      res(0, 1);
      WP_N <= 1'b0;
      i_mst.frame(0, '{8'h44, 8'h00}, 0, 9);
      res(1, 0);
      chk(AREA_GUARD, 3'h1);
      WP_N <= 1'b1;
      i_mst.frame(0, '{8'h22, 8'h00, 8'h00, 8'h00}, 4, 9);
      res(0, 1);
      i_mst.frame(0, '{8'h11, 8'h00, 8'h00, 8'h00}, 0, 9);
      res(0, 1);
      n_rx = 0;
      i_mst.cut();
      res(0, 0);
      chk(n_rx, 0);
      i_mst.frame(1, '{8'h55, 8'h00, 8'h00}, 0, 9);
      res(0, 0);
      chk({i_mst.rx[1], i_mst.rx[2]}, ID);
      chk({SELECTED, SDO_OE}, 2'h0);
      summarize();
   end
endmodule
`default_nettype wire

/* sfp_sync.sv */
// sfp_sync.sv: two-flop synchroniser for asynchronous pins
// assumes: d is unrelated to clk; q is safe to use after two edges
`timescale 1ns/100ps
`default_nettype none

module sfp_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;   // first stage, read only by q

   // ----------------------------------------------------------------
   // two stages; reset to the pin's idle level to avoid false edges
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_r <= INIT;
         q      <= INIT;
      end
      else if (ce)
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule
`default_nettype wire
